// ==== core/slp_pkg.sv ====
// constants and types shared by the serial programming lock port
package slp_pkg;
  localparam int unsigned SYS_CLK_MHZ      = 50;
  localparam int unsigned ENTRY_LOW_SYSCLK = 64;
  localparam int unsigned SCK_RATIO        = 16;
  localparam logic [7:0]  OPC_PAGE_READ    = 8'h30;
  localparam logic [7:0]  OPC_PAGE_WRITE   = 8'h50;
  localparam int unsigned PAGE_BYTES       = 256;
  localparam logic [7:0]  PAGE_LAST        = 8'hff;
  localparam logic [7:0]  PAGE_FIRST       = 8'h00;
  localparam logic [2:0]  BIT_LAST         = 3'h7;
  localparam logic [2:0]  BIT_FIRST        = 3'h0;
  localparam int unsigned ADDR_W           = 13;
  localparam int unsigned PAGE_ADDR_W      = 5;
  localparam logic [1:0]  LOCK_RESET       = 2'h0;

  typedef enum logic [3:0] {
    SLP_MODE1 = 4'h1,
    SLP_MODE2 = 4'h2,
    SLP_MODE3 = 4'h4,
    SLP_MODE4 = 4'h8
  } slp_lock_mode_e;

  typedef enum logic [3:0] {
    SLP_IDLE  = 4'h1,
    SLP_CMD   = 4'h2,
    SLP_ADDR  = 4'h4,
    SLP_DATA  = 4'h8
  } slp_state_e;

  // lock field: high bit then low bit
  function automatic slp_lock_mode_e slp_decode_lock(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'h0:    slp_decode_lock = SLP_MODE1;
      2'h1:    slp_decode_lock = SLP_MODE2;
      2'h2:    slp_decode_lock = SLP_MODE3;
      default: slp_decode_lock = SLP_MODE4;
    endcase
  endfunction
endpackage

// ==== core/slp_mem_if.sv ====
// page memory port between the controller and its memory
`timescale 1ns/10ps
interface slp_mem_if;
  logic [12:0] addr;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
  modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// ==== core/slp_mem.sv ====
// program flash array model, registered read data
`timescale 1ns/10ps
module slp_mem (
  // clock
  input  wire logic ref_clk,
  input  wire logic clk_en,
  // access port
  slp_mem_if.mem    port
);
  import slp_pkg::*;
  logic [7:0] array_reg [0:(1<<ADDR_W)-1];
  logic [7:0] rd_reg;

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (port.wr_en) begin
        array_reg[port.addr] <= port.wr_data;
      end
      rd_reg <= array_reg[port.addr];
    end
  end
  assign port.rd_data = rd_reg;
endmodule

// ==== core/slp_top.sv ====
// serial in-system programming port with page read/write and lock decode
`timescale 1ns/10ps
// Function
// (R1) lock field bits decode to modes one to four as printed.
// (R2) programmer applies lock modes in ascending order before mode four.
// (R3) programmer keeps serial clock low 64 system clocks after reset high.
// (R4) entry needs reset held high only; no reset pulse required.
// (R5) serial clock stays at or below one sixteenth of system clock; the programmer model runs it at one eighth (eight system clocks per period).
// (R6) page data runs from byte 0 through byte 255 in order.
// (R7) command byte then upper address byte latched before any data.
// (R8) exactly 256 data bytes follow the header bytes.
// (R9) after the last data byte the next byte decodes as a command.
// (R10) page read opcode 0011 0000 returns 256 bytes.
// (R11) page write opcode 0101 0000 accepts 256 bytes.
// (R12) programming active only while reset high; drop partial transfer on low.
module slp_top (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  input  wire logic            clk_en,
  // programming pins
  input  wire logic            prog_rst,
  input  wire logic            sck,
  input  wire logic            mosi,
  output logic                 miso,
  output logic                 miso_oe,
  // lock field
  input  wire logic            lock_field_high_bit,
  input  wire logic            lock_field_low_bit,
  output slp_pkg::slp_lock_mode_e lock_mode,
  // status
  output logic                 prog_active,
  output logic                 page_busy
);
  import slp_pkg::*;

  logic       rst_s1_reg, rst_s2_reg;
  logic [1:0] prst_sync_reg, sck_sync_reg, mosi_sync_reg;
  logic       sck_prev_reg;
  logic       sck_rise, sck_fall, prog_rst_s, mosi_s;
  slp_state_e state_reg;
  logic [7:0] cmd_reg, shift_reg, byte_cnt_reg, rd_shift_reg;
  logic [PAGE_ADDR_W-1:0] page_reg;
  logic [2:0] bit_cnt_reg;
  logic       wr_pulse_reg, byte_done;
  logic [7:0] rx_byte;
  slp_mem_if  mem_bus ();

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // two-flop synchronisers; bit 0 is the first stage, read only by bit 1
  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      prst_sync_reg <= 2'h0;
      sck_sync_reg  <= 2'h0;
      mosi_sync_reg <= 2'h0;
      sck_prev_reg  <= 1'b0;
    end else if (clk_en) begin
      prst_sync_reg <= {prst_sync_reg[0], prog_rst};
      sck_sync_reg  <= {sck_sync_reg[0], sck};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi};
      sck_prev_reg  <= sck_sync_reg[1];
    end
  end
  assign prog_rst_s = prst_sync_reg[1];
  assign mosi_s     = mosi_sync_reg[1];
  assign sck_rise   = sck_sync_reg[1] & ~sck_prev_reg;
  assign sck_fall   = ~sck_sync_reg[1] & sck_prev_reg;
  assign rx_byte    = {shift_reg[6:0], mosi_s};
  assign byte_done  = sck_rise && (bit_cnt_reg == BIT_LAST);

  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      lock_mode <= SLP_MODE1;
    end else if (clk_en) begin
      lock_mode <= slp_decode_lock(lock_field_high_bit, lock_field_low_bit); // R1
    end
  end

  // bit shifter; reset level low abandons partial bytes
  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      shift_reg   <= 8'h00;
      bit_cnt_reg <= BIT_FIRST;
    end else if (clk_en) begin
      if (!prog_rst_s) begin
        shift_reg   <= 8'h00; // R12
        bit_cnt_reg <= BIT_FIRST;
      end else if (sck_rise) begin
        shift_reg   <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  end

  // frame sequencer: command, upper address, then page data
  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      state_reg    <= SLP_IDLE;
      cmd_reg      <= 8'h00;
      page_reg     <= '0;
      byte_cnt_reg <= PAGE_FIRST;
    end else if (clk_en) begin
      if (!prog_rst_s) begin
        state_reg    <= SLP_IDLE; // R12
        byte_cnt_reg <= PAGE_FIRST;
      end else begin
        unique case (state_reg)
          SLP_IDLE: begin
            state_reg <= SLP_CMD; // R4
          end
          SLP_CMD: begin
            if (byte_done) begin
              cmd_reg   <= rx_byte; // R7
              state_reg <= SLP_ADDR;
            end
          end
          SLP_ADDR: begin
            if (byte_done) begin
              page_reg     <= rx_byte[PAGE_ADDR_W-1:0]; // R7
              byte_cnt_reg <= PAGE_FIRST; // R6
              if (cmd_reg == OPC_PAGE_READ || cmd_reg == OPC_PAGE_WRITE) begin
                state_reg <= SLP_DATA; // R10 R11
              end else begin
                state_reg <= SLP_CMD;
              end
            end
          end
          SLP_DATA: begin
            if (byte_done) begin
              byte_cnt_reg <= byte_cnt_reg + 8'h01; // R6
              if (byte_cnt_reg == PAGE_LAST) begin
                state_reg <= SLP_CMD; // R8 R9
              end
            end
          end
          default: state_reg <= SLP_IDLE;
        endcase
      end
    end
  end

  // memory port: write on each received data byte of a page write
  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      wr_pulse_reg <= 1'b0;
    end else if (clk_en) begin
      wr_pulse_reg <= prog_rst_s && state_reg == SLP_DATA && byte_done
                      && cmd_reg == OPC_PAGE_WRITE; // R11
    end
  end
  always_ff @(posedge ref_clk) begin
    if (clk_en && byte_done) begin
      mem_bus.wr_data <= rx_byte;
    end
  end
  assign mem_bus.addr  = {page_reg, byte_cnt_reg - {7'h0, wr_pulse_reg}};
  assign mem_bus.wr_en = wr_pulse_reg;

  slp_mem u_mem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .port    (mem_bus.mem)
  );

  // read path: load byte at the falling edge after the previous byte's last rise, shift msb first
  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      rd_shift_reg <= 8'h00;
      miso         <= 1'b0;
      miso_oe      <= 1'b0;
    end else if (clk_en) begin
      miso_oe <= prog_rst_s && state_reg == SLP_DATA && cmd_reg == OPC_PAGE_READ; // R10
      if (sck_fall && bit_cnt_reg == BIT_FIRST) begin
        rd_shift_reg <= {mem_bus.rd_data[6:0], 1'b0};
        miso         <= mem_bus.rd_data[7];
      end else if (sck_fall) begin
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        miso         <= rd_shift_reg[7];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      prog_active <= 1'b0;
      page_busy   <= 1'b0;
    end else if (clk_en) begin
      prog_active <= prog_rst_s; // R12
      page_busy   <= prog_rst_s && state_reg == SLP_DATA;
    end
  end
endmodule

// ==== dv/slp_top_asserts.sv ====
// pin-level assertions for the serial programming lock port
`timescale 1ns/10ps
module slp_top_asserts (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    arst_n,
  input wire logic                    clk_en,
  // programming pins
  input wire logic                    prog_rst,
  input wire logic                    sck,
  input wire logic                    miso,
  input wire logic                    miso_oe,
  // lock field and status
  input wire logic                    lock_field_high_bit,
  input wire logic                    lock_field_low_bit,
  input wire slp_pkg::slp_lock_mode_e lock_mode,
  input wire logic                    prog_active,
  input wire logic                    page_busy
);
  import slp_pkg::*;
  logic [2:0]  up_reg;
  logic        sck_reg;
  logic [11:0] rise_reg;
  // masks the internal two-flop reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) up_reg <= 3'h0;
    else up_reg <= {up_reg[1:0], 1'b1};
  end
  // serial clock rises seen during a data phase
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_reg  <= 1'b0;
      rise_reg <= 12'h000;
    end else begin
      sck_reg <= sck;
      if (!page_busy) rise_reg <= 12'h000;
      else if (sck && !sck_reg) rise_reg <= rise_reg + 12'h001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !up_reg[2]);
  AST_LOCK_DECODE: assert property ($past(clk_en) |->
    lock_mode == (4'h1 << {$past(lock_field_high_bit), $past(lock_field_low_bit)}))
    else $error("lock mode does not follow lock field");
  AST_LOCK_ONEHOT: assert property ($onehot(lock_mode))
    else $error("lock mode not one-hot");
  AST_ACTIVE_DROP: assert property (!prog_rst [*4] |-> !prog_active)
    else $error("active while reset pin low");
  AST_ENTRY_HELD: assert property (prog_rst [*4] |-> prog_active)
    else $error("not active while reset pin held high");
  AST_IDLE_QUIET: assert property (!prog_active [*2] |-> !page_busy && !miso_oe)
    else $error("page transfer alive outside programming");
  AST_OE_BUSY: assert property ($rose(miso_oe) |-> page_busy)
    else $error("miso driven outside data phase");
  AST_MISO_HOLD: assert property (sck [*4] |-> $stable(miso))
    else $error("miso moved while serial clock high");
  AST_PAGE_COUNT: assert property ($fell(page_busy) && prog_rst |-> rise_reg == 12'h800)
    else $error("data phase not 256 bytes long");
  AST_FREEZE_HOLD: assert property (!$past(clk_en) |-> $stable(lock_mode) && $stable(miso)
    && $stable(miso_oe) && $stable(prog_active) && $stable(page_busy))
    else $error("outputs moved while clock enable low");
endmodule
bind slp_top slp_top_asserts CHK (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
  .prog_rst(prog_rst), .sck(sck), .miso(miso), .miso_oe(miso_oe),
  .lock_field_high_bit(lock_field_high_bit), .lock_field_low_bit(lock_field_low_bit),
  .lock_mode(lock_mode), .prog_active(prog_active), .page_busy(page_busy));

// ==== dv/slp_prog_model.sv ====
// external programmer model driving the serial programming pins
`timescale 1ns/10ps
module slp_prog_model (
  // clock
  input  wire logic ref_clk,
  // programming pins
  output logic      prog_rst,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  import slp_pkg::*;
  initial begin
    prog_rst = 1'b0;
    sck      = 1'b0;
    mosi     = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // entry holds the level only, serial clock kept low meanwhile
  task automatic enter();
    prog_rst = 1'b1;
    wait_clk(ENTRY_LOW_SYSCLK);
  endtask
  task automatic leave();
    prog_rst = 1'b0;
  endtask
  // msb first, eight system clocks per serial period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      wait_clk(4);
      sck   = 1'b1;
      rx[i] = miso;
      wait_clk(4);
      sck = 1'b0;
    end
  endtask
endmodule

// ==== dv/slp_top_bench.sv ====
// self-checking bench for the serial programming lock port
`timescale 1ns/10ps
module slp_top_bench;
  import slp_pkg::*;
  logic           ref_clk, arst_n, lf_hi, lf_lo, prog_rst, sck, mosi, miso, miso_oe;
  logic           prog_active, page_busy, clk_en, miso_pin;
  logic [7:0]     rx;
  slp_lock_mode_e lock_mode;
  int             err_count;
  int             check_count;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // released pin shows the inverse so a late enable corrupts the read
  assign miso_pin = miso_oe ? miso : ~miso;
  slp_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .prog_rst(prog_rst),
    .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .lock_field_high_bit(lf_hi),
    .lock_field_low_bit(lf_lo), .lock_mode(lock_mode), .prog_active(prog_active),
    .page_busy(page_busy));
  slp_prog_model PRG (.ref_clk(ref_clk), .prog_rst(prog_rst), .sck(sck), .mosi(mosi),
    .miso(miso_pin));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_lock();
    for (int i = 0; i < 4; i++) begin
      {lf_hi, lf_lo} = i[1:0];
      PRG.wait_clk(2);
      chk("lock_mode", 8'h01 << i, lock_mode);
    end
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    {lf_hi, lf_lo} = 2'h0;
    PRG.wait_clk(4);
    chk("frozen lock_mode", SLP_MODE4, lock_mode);
    clk_en = 1'b1;
    PRG.wait_clk(2);
    chk("thawed lock_mode", SLP_MODE1, lock_mode);
  endtask
  task automatic t_write(input logic [7:0] pg, input logic [7:0] k, input int n);
    PRG.xfer(OPC_PAGE_WRITE, rx);
    PRG.xfer(pg, rx);
    PRG.wait_clk(4);
    chk("page_busy", 8'h01, page_busy);
    for (int i = 0; i < n; i++) PRG.xfer(i[7:0] ^ k, rx);
  endtask
  task automatic t_read(input logic [7:0] pg, input logic [7:0] k);
    PRG.xfer(OPC_PAGE_READ, rx);
    PRG.xfer(pg, rx);
    for (int i = 0; i < 256; i++) begin
      PRG.xfer(8'h00, rx);
      chk("read byte", i[7:0] ^ k, rx);
    end
    PRG.wait_clk(8);
    chk("page_busy after read", 8'h00, page_busy);
    chk("miso_oe after read", 8'h00, miso_oe);
  endtask
  task automatic t_abort();
    t_write(8'h04, 8'h3c, 5);
    PRG.leave();
    PRG.wait_clk(8);
    chk("prog_active", 8'h00, prog_active);
    chk("page_busy", 8'h00, page_busy);
    PRG.enter();
  endtask
  initial begin
    err_count   = 0;
    check_count = 0;
    arst_n      = 1'b0;
    lf_hi       = 1'b0;
    lf_lo       = 1'b0;
    clk_en      = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("reset lock_mode", SLP_MODE1, lock_mode);
    arst_n = 1'b1;
    PRG.wait_clk(4);
    t_lock();
    t_freeze();
    PRG.enter();
    chk("prog_active", 8'h01, prog_active);
    t_write(8'h03, 8'ha5, 256);
    PRG.wait_clk(8);
    chk("page_busy after write", 8'h00, page_busy);
    t_abort();
    t_read(8'h03, 8'ha5);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
endmodule
